// [hdl/keypad_lock_pkg.sv]
/*
 * Shared constants and types for the keypad security menu controller.
 * Assumes one clock domain (pclk, 200 MHz) and an APB3 master outside.
 */
package keypad_lock_pkg;

	// ==================================================
	// register map (byte addresses)
	localparam logic [11:0] ADDR_KEY         = 12'h000;
	localparam logic [11:0] ADDR_STATUS      = 12'h004;
	localparam logic [11:0] ADDR_PASS_ENTRY  = 12'h008;
	localparam logic [11:0] ADDR_PASS_DEF    = 12'h00C;
	localparam logic [11:0] ADDR_MASK        = 12'h010;
	localparam logic [11:0] ADDR_DISPLAY     = 12'h014;
	localparam logic [11:0] ADDR_ERR_CYCLES  = 12'h018;
	localparam logic [11:0] ADDR_PLANT       = 12'h01C;

	// ==================================================
	// key codes written into the key register
	localparam logic [3:0] KEY_NONE     = 4'h0;
	localparam logic [3:0] KEY_UP       = 4'h1;
	localparam logic [3:0] KEY_DOWN     = 4'h2;
	localparam logic [3:0] KEY_LEFT     = 4'h3;
	localparam logic [3:0] KEY_RIGHT    = 4'h4;
	localparam logic [3:0] KEY_ENTER    = 4'h5;
	localparam logic [3:0] KEY_SECURITY = 4'h6;
	localparam logic [3:0] KEY_VAR      = 4'h7;
	localparam logic [3:0] KEY_SETPT    = 4'h8;
	localparam logic [3:0] KEY_DIAGNOSTIC_MENU_KEY     = 4'h9;

	// ==================================================
	// six BCD digits per security variable
	localparam int DIGITS = 6;
	localparam logic [23:0] PASS_ENTRY_RESET = 24'h000332;
	localparam logic [23:0] PASS_DEF_RESET   = 24'h000332;
	localparam logic [23:0] MASK_RESET       = 24'h000000;

	// mask digit positions (digit 0 is right-most)
	localparam int MASK_VAR_EDIT   = 4;
	localparam int MASK_SETPT_EDIT = 3;
	localparam int MASK_DIAGNOSTIC_MENU_KEY       = 2;
	localparam int MASK_SP_SCROLL  = 1;
	localparam int MASK_AR_SCROLL  = 0;

	// variable selection
	localparam logic [1:0] SEL_ENTRY = 2'd0;
	localparam logic [1:0] SEL_DEF   = 2'd1;
	localparam logic [1:0] SEL_MASK  = 2'd2;

	// display code for the concealment mnemonic (not a digit pattern)
	localparam logic [23:0] CONCEALED_CODE = 24'hFFFFFF;

	// error stretch: time and derived cycles
	localparam int CLK_MHZ       = 200;
	localparam int ERR_TIME_NS   = 100;
	localparam logic [15:0] ERR_CYCLES_RESET = 16'(ERR_TIME_NS * CLK_MHZ / 1000);

	typedef enum logic [2:0] {
		MENU_IDLE   = 3'b000,
		MENU_SEC_L1 = 3'b001,
		MENU_SEC_L2 = 3'b011,
		MENU_VAR    = 3'b010,
		MENU_SETPT  = 3'b110,
		MENU_DIAGNOSTIC_MENU_KEY   = 3'b111
	} menu_t;

	typedef struct packed {
		logic        program_led;
		logic        setpoint_speed_led;
		logic        all_flash;
		logic [5:0]  flash_digit;
		logic        concealed_indicator;
		logic [23:0] digits;
	} display_t;

	typedef struct packed {
		logic var_edit_en;
		logic setpt_edit_en;
		logic sp_scroll_en;
		logic ar_scroll_en;
		logic control_en;
	} gates_t;

endpackage : keypad_lock_pkg

// [hdl/bcd_digit_step.sv]
/*
 * Steps one BCD digit of a six digit word up or down with decade wrap.
 * Assumes digit index 0..5 and valid BCD input.
 */
`timescale 1ns/1ps
`default_nettype none

module bcd_digit_step (
	input  wire logic [23:0] value_in,   // current value
	input  wire logic [2:0]  position,   // digit to step
	input  wire logic        step_down,  // 1 = decrement
	input  wire logic        binary,     // mask digits toggle 0/1 only
	output logic      [23:0] value_out   // stepped value
);
	logic [3:0] cur;
	logic [3:0] nxt;

	always_comb begin
		cur = value_in[position*4 +: 4];
		if (binary) begin
			nxt = (cur == 4'h0) ? 4'h1 : 4'h0;
		end else if (step_down) begin
			nxt = (cur == 4'h0) ? 4'h9 : cur - 4'h1;
		end else begin
			nxt = (cur >= 4'h9) ? 4'h0 : cur + 4'h1;
		end
		value_out = value_in;
		value_out[position*4 +: 4] = nxt;
	end
endmodule // bcd_digit_step

`default_nettype wire

// [hdl/err_stretch.sv]
/*
 * Stretches a one-cycle error event into a lamp pulse of a set length.
 * Assumes the length register is at least one.
 */
`timescale 1ns/1ps
`default_nettype none

module err_stretch (
	input  wire logic        pclk,      // clock
	input  wire logic        presetn,   // async reset, low
	input  wire logic        trigger,   // one-cycle error event
	input  wire logic [15:0] length,    // lamp length in cycles
	output logic             err_led    // error lamp
);
	logic [15:0] count_reg;

	// a new event restarts the count rather than being lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 16'h0000;
		end else if (trigger) begin
			count_reg <= (length == 16'h0000) ? 16'h0001 : length;
		end else if (count_reg != 16'h0000) begin
			count_reg <= count_reg - 16'h0001;
		end
	end

	assign err_led = (count_reg != 16'h0000);
endmodule // err_stretch

`default_nettype wire

// [hdl/keypad_lock_menu.sv]
/*
 * Keypad security menu controller with an APB3 register slave.
 * Assumes an APB3 master; keys arrive as writes to the key register.
 */
`timescale 1ns/1ps
`default_nettype none

module keypad_lock_menu (
	input  wire logic        pclk,             // 200 MHz clock
	input  wire logic        presetn,          // async reset, low
	input  wire logic        psel,             // APB select
	input  wire logic        penable,          // APB enable
	input  wire logic        pwrite,           // APB direction
	input  wire logic [11:0] paddr,            // APB byte address
	input  wire logic [31:0] pwdata,           // APB write data
	output logic      [31:0] prdata,           // APB read data
	output logic             pready,           // APB ready
	output logic             pslverr,          // APB error
	input  wire logic        run_switch,       // run/stop input, 1 = closed
	input  wire logic [11:0] converter_code,   // output converter code
	output logic             program_led,      // program lamp
	output logic             setpoint_speed_led, // setpoint-speed lamp
	output logic             err_led,          // error lamp
	output keypad_lock_pkg::display_t display, // display contents
	output keypad_lock_pkg::gates_t   gates    // lock-effect gates to the controller
);
	keypad_lock_pkg::menu_t menu_reg;
	// selection survives leaving the menu, so it reopens on the last variable
	logic [1:0]  sel_reg;
	logic [2:0]  pos_reg;
	logic [23:0] edit_reg;
	logic [23:0] pass_entry_reg;
	logic [23:0] pass_def_reg;
	logic [23:0] mask_reg;
	logic [15:0] err_cycles_reg;
	logic        unlocked;
	logic        key_valid;
	logic [3:0]  key_code;
	logic        err_event;
	logic        edit_locked;
	logic        diagnostic_menu_key_ok;
	logic [23:0] stepped;
	logic        apb_access;
	logic        addr_ok;

	// ==================================================
	// APB slave: zero wait, unmapped addresses flag an error
	assign apb_access = psel && penable;
	assign pready     = 1'b1;
	always_comb begin
		case (paddr)
			keypad_lock_pkg::ADDR_KEY,
			keypad_lock_pkg::ADDR_STATUS,
			keypad_lock_pkg::ADDR_PASS_ENTRY,
			keypad_lock_pkg::ADDR_PASS_DEF,
			keypad_lock_pkg::ADDR_MASK,
			keypad_lock_pkg::ADDR_DISPLAY,
			keypad_lock_pkg::ADDR_ERR_CYCLES,
			keypad_lock_pkg::ADDR_PLANT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr   = apb_access && !addr_ok;
	assign key_valid = apb_access && pwrite && (paddr == keypad_lock_pkg::ADDR_KEY);
	assign key_code  = pwdata[3:0];

	always_comb begin
		prdata = 32'h00000000;
		case (paddr)
			keypad_lock_pkg::ADDR_STATUS:
				prdata = {19'h0, gates, pos_reg, sel_reg, menu_reg};
			keypad_lock_pkg::ADDR_PASS_ENTRY: prdata = {8'h00, pass_entry_reg};
			// concealed while locked
			keypad_lock_pkg::ADDR_PASS_DEF:
				prdata = unlocked ? {8'h00, pass_def_reg} : 32'h00000000;
			keypad_lock_pkg::ADDR_MASK:       prdata = {8'h00, mask_reg};
			keypad_lock_pkg::ADDR_DISPLAY:    prdata = {8'h00, display.digits};
			keypad_lock_pkg::ADDR_ERR_CYCLES: prdata = {16'h0000, err_cycles_reg};
			keypad_lock_pkg::ADDR_PLANT:
				prdata = {19'h0, run_switch, converter_code};
			default: prdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_cycles_reg <= keypad_lock_pkg::ERR_CYCLES_RESET;
		end else if (apb_access && pwrite && paddr == keypad_lock_pkg::ADDR_ERR_CYCLES) begin
			err_cycles_reg <= pwdata[15:0];
		end
	end

	// ==================================================
	// lock state and gates
	assign unlocked = (pass_entry_reg == pass_def_reg);
	// definition and mask are frozen while locked
	assign edit_locked = !unlocked && (sel_reg != keypad_lock_pkg::SEL_ENTRY);
	assign diagnostic_menu_key_ok = !run_switch && (converter_code == 12'h000)
		&& (unlocked || mask_reg[keypad_lock_pkg::MASK_DIAGNOSTIC_MENU_KEY*4] == 1'b0);

	always_comb begin
		// control keeps running except inside diagnostics
		gates.control_en    = (menu_reg != keypad_lock_pkg::MENU_DIAGNOSTIC_MENU_KEY);
		gates.var_edit_en   = unlocked || !mask_reg[keypad_lock_pkg::MASK_VAR_EDIT*4];
		gates.setpt_edit_en = unlocked || !mask_reg[keypad_lock_pkg::MASK_SETPT_EDIT*4];
		gates.sp_scroll_en  = unlocked || !mask_reg[keypad_lock_pkg::MASK_SP_SCROLL*4];
		gates.ar_scroll_en  = unlocked || !mask_reg[keypad_lock_pkg::MASK_AR_SCROLL*4];
	end

	bcd_digit_step u_step (
		.value_in  (edit_reg),
		.position  (pos_reg),
		.step_down (key_code == keypad_lock_pkg::KEY_DOWN),
		.binary    (sel_reg == keypad_lock_pkg::SEL_MASK),
		.value_out (stepped)
	);

	// ==================================================
	// menu state machine
	always_comb begin
		err_event = 1'b0;
		if (key_valid) begin
			case (menu_reg)
				keypad_lock_pkg::MENU_IDLE:
					err_event = (key_code == keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY) && !diagnostic_menu_key_ok;
				keypad_lock_pkg::MENU_SEC_L1:
					err_event = (key_code == keypad_lock_pkg::KEY_VAR)
						|| (key_code == keypad_lock_pkg::KEY_SETPT)
						|| (key_code == keypad_lock_pkg::KEY_LEFT)
						|| (key_code == keypad_lock_pkg::KEY_RIGHT)
						|| (key_code == keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY);
				keypad_lock_pkg::MENU_SEC_L2:
					err_event = (key_code == keypad_lock_pkg::KEY_VAR)
						|| (key_code == keypad_lock_pkg::KEY_SETPT)
						|| (key_code == keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY)
						|| (edit_locked && (key_code == keypad_lock_pkg::KEY_UP
						|| key_code == keypad_lock_pkg::KEY_DOWN
						|| key_code == keypad_lock_pkg::KEY_ENTER));
				default: err_event = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			menu_reg <= keypad_lock_pkg::MENU_IDLE;
			sel_reg  <= keypad_lock_pkg::SEL_ENTRY;
			pos_reg  <= 3'd0;
			edit_reg <= 24'h000000;
		end else if (key_valid && !err_event) begin
			case (menu_reg)
				keypad_lock_pkg::MENU_IDLE: begin
					case (key_code)
						keypad_lock_pkg::KEY_SECURITY: menu_reg <= keypad_lock_pkg::MENU_SEC_L1;
						keypad_lock_pkg::KEY_VAR:      menu_reg <= keypad_lock_pkg::MENU_VAR;
						keypad_lock_pkg::KEY_SETPT:    menu_reg <= keypad_lock_pkg::MENU_SETPT;
						keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY:     menu_reg <= keypad_lock_pkg::MENU_DIAGNOSTIC_MENU_KEY;
						default: menu_reg <= menu_reg;
					endcase
				end
				keypad_lock_pkg::MENU_SEC_L1: begin
					case (key_code)
						keypad_lock_pkg::KEY_UP:
							sel_reg <= (sel_reg == keypad_lock_pkg::SEL_MASK)
								? keypad_lock_pkg::SEL_ENTRY : sel_reg + 2'd1;
						keypad_lock_pkg::KEY_DOWN:
							sel_reg <= (sel_reg == keypad_lock_pkg::SEL_ENTRY)
								? keypad_lock_pkg::SEL_MASK : sel_reg - 2'd1;
						keypad_lock_pkg::KEY_ENTER: begin
							menu_reg <= keypad_lock_pkg::MENU_SEC_L2;
							pos_reg  <= 3'd0;
							case (sel_reg)
								keypad_lock_pkg::SEL_ENTRY: edit_reg <= pass_entry_reg;
								keypad_lock_pkg::SEL_DEF:   edit_reg <= pass_def_reg;
								default:                    edit_reg <= mask_reg;
							endcase
						end
						keypad_lock_pkg::KEY_SECURITY: menu_reg <= keypad_lock_pkg::MENU_IDLE;
						default: menu_reg <= menu_reg;
					endcase
				end
				keypad_lock_pkg::MENU_SEC_L2: begin
					case (key_code)
						keypad_lock_pkg::KEY_UP, keypad_lock_pkg::KEY_DOWN:
							edit_reg <= stepped;
						// mask keeps its left-most digit at zero, so it wraps after digit four
						keypad_lock_pkg::KEY_LEFT:
							pos_reg <= (pos_reg >= ((sel_reg == keypad_lock_pkg::SEL_MASK)
								? 3'd4 : 3'd5)) ? 3'd0 : pos_reg + 3'd1;
						keypad_lock_pkg::KEY_RIGHT:
							pos_reg <= (pos_reg == 3'd0) ? ((sel_reg == keypad_lock_pkg::SEL_MASK)
								? 3'd4 : 3'd5) : pos_reg - 3'd1;
						keypad_lock_pkg::KEY_ENTER:    menu_reg <= keypad_lock_pkg::MENU_SEC_L1;
						keypad_lock_pkg::KEY_SECURITY: menu_reg <= keypad_lock_pkg::MENU_IDLE;
						default: menu_reg <= menu_reg;
					endcase
				end
				// other menus are left with their own key; nothing else here
				keypad_lock_pkg::MENU_VAR:
					if (key_code == keypad_lock_pkg::KEY_VAR) menu_reg <= keypad_lock_pkg::MENU_IDLE;
				keypad_lock_pkg::MENU_SETPT:
					if (key_code == keypad_lock_pkg::KEY_SETPT) menu_reg <= keypad_lock_pkg::MENU_IDLE;
				keypad_lock_pkg::MENU_DIAGNOSTIC_MENU_KEY:
					if (key_code == keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY) menu_reg <= keypad_lock_pkg::MENU_IDLE;
				default: menu_reg <= keypad_lock_pkg::MENU_IDLE;
			endcase
		end
	end

	// ==================================================
	// committed security variables, effective at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pass_entry_reg <= keypad_lock_pkg::PASS_ENTRY_RESET;
			pass_def_reg   <= keypad_lock_pkg::PASS_DEF_RESET;
			mask_reg       <= keypad_lock_pkg::MASK_RESET;
		end else if (key_valid && !err_event && menu_reg == keypad_lock_pkg::MENU_SEC_L2
			&& key_code == keypad_lock_pkg::KEY_ENTER) begin
			case (sel_reg)
				keypad_lock_pkg::SEL_ENTRY: pass_entry_reg <= edit_reg;
				keypad_lock_pkg::SEL_DEF:   pass_def_reg   <= edit_reg;
				default:                    mask_reg       <= {4'h0, edit_reg[19:0]};
			endcase
		end
	end

	err_stretch u_err (
		.pclk    (pclk),
		.presetn (presetn),
		.trigger (err_event),
		.length  (err_cycles_reg),
		.err_led (err_led)
	);

	// ==================================================
	// lamps and display
	always_comb begin
		display = '0;
		if (menu_reg == keypad_lock_pkg::MENU_SEC_L1) begin
			display.all_flash = 1'b1;
			display.digits    = {22'h000000, sel_reg};
		end else if (menu_reg == keypad_lock_pkg::MENU_SEC_L2) begin
			display.flash_digit = 6'd1 << pos_reg;
			if (sel_reg == keypad_lock_pkg::SEL_DEF && !unlocked) begin
				display.concealed_indicator = 1'b1;
				display.digits = keypad_lock_pkg::CONCEALED_CODE;
			end else begin
				display.digits = edit_reg;
			end
		end
		display.program_led        = program_led;
		display.setpoint_speed_led = setpoint_speed_led;
	end

	assign program_led = (menu_reg == keypad_lock_pkg::MENU_SEC_L1)
		|| (menu_reg == keypad_lock_pkg::MENU_SEC_L2);
	assign setpoint_speed_led = program_led;

endmodule // keypad_lock_menu

`default_nettype wire

// [tb/keypad_lock_menu_sva.sv]
/*
 * Port checker for the keypad security menu controller.
 * Assumes one clock domain and is attached by a bind in the bench top.
 */
`timescale 1ns/1ps
`default_nettype none

module keypad_lock_menu_sva (
	input wire logic                     pclk,               // clock
	input wire logic                     presetn,            // async reset, low
	input wire logic                     psel,               // APB select
	input wire logic                     penable,            // APB enable
	input wire logic                     pwrite,             // APB direction
	input wire logic [11:0]              paddr,              // APB address
	input wire logic [31:0]              pwdata,             // APB write data
	input wire logic                     pready,             // APB ready
	input wire logic                     pslverr,            // APB error
	input wire logic                     run_switch,         // run/stop input
	input wire logic [11:0]              converter_code,     // converter code
	input wire logic                     program_led,        // program lamp
	input wire logic                     setpoint_speed_led, // setpoint lamp
	input wire logic                     err_led,            // error lamp
	input wire keypad_lock_pkg::display_t display,           // display
	input wire keypad_lock_pkg::gates_t   gates              // gates
);
	// ==================================================
	// key events and menu levels seen from the lamps
	logic       key_wr;
	logic [3:0] key;
	logic       lvl1;
	logic       lvl2;
	assign key_wr = psel && penable && pwrite && (paddr == keypad_lock_pkg::ADDR_KEY);
	assign key    = pwdata[3:0];
	assign lvl1   = program_led && display.all_flash;
	assign lvl2   = program_led && !display.all_flash;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==================================================
	// properties
	ready_high_a: assert property (psel |-> pready)
		else $error("ready low during a transfer");
	unmapped_err_a: assert property (psel && penable && paddr > keypad_lock_pkg::ADDR_PLANT |-> pslverr)
		else $error("no slave error on unmapped address");
	lamps_pair_a: assert property ((program_led == setpoint_speed_led) && (!display.all_flash || program_led))
		else $error("lamps disagree with level");
	select_cycle_a: assert property (key_wr && lvl1 && key == keypad_lock_pkg::KEY_UP |=> lvl1 && display.digits != $past(display.digits))
		else $error("selection did not move");
	enter_level_a: assert property (key_wr && lvl1 && key == keypad_lock_pkg::KEY_ENTER |=> lvl2 && display.flash_digit == 6'h01)
		else $error("confirm did not open value view");
	leave_menu_a: assert property (key_wr && lvl1 && key == keypad_lock_pkg::KEY_SECURITY |=> !program_led)
		else $error("security key did not leave level one");
	discard_edit_a: assert property (key_wr && lvl2 && key == keypad_lock_pkg::KEY_SECURITY |=> !program_led)
		else $error("security key did not leave level two");
	move_left_a: assert property (key_wr && lvl2 && key == keypad_lock_pkg::KEY_LEFT && !display.flash_digit[5]
		|=> display.flash_digit == ($past(display.flash_digit) << 1))
		else $error("flashing digit did not move left");
	refused_hold_a: assert property ($rose(err_led) |-> $stable(display) && $stable(program_led))
		else $error("refused key changed the display");
	concealed_a: assert property (display.concealed_indicator |-> display.digits == keypad_lock_pkg::CONCEALED_CODE)
		else $error("concealed view shows digits");
	diagnostic_menu_key_entry_a: assert property ($fell(gates.control_en) |-> !$past(run_switch) && $past(converter_code) == 12'h000)
		else $error("control stopped while running");
endmodule // keypad_lock_menu_sva

`default_nettype wire

// [tb/panel_operator.sv]
/*
 * Operator model: presses keys and reads values as an APB master.
 * Assumes a zero or more wait slave on the same pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module panel_operator (
	input  wire logic        pclk,    // clock
	input  wire logic        pready,  // slave ready
	input  wire logic [31:0] prdata,  // read data
	input  wire logic        pslverr, // slave error
	output var  logic        psel,    // select
	output var  logic        penable, // enable
	output var  logic        pwrite,  // direction
	output var  logic [11:0] paddr,   // address
	output var  logic [31:0] pwdata   // write data
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'hFFF;
		pwdata = 32'h0;
	end

	// ==================================================
	// one transfer; released address and data show the inverse so stale values never pass
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	// keeping the keypad locked is the operator's habit, the bench ends unlocked on purpose
endmodule // panel_operator

`default_nettype wire

// [tb/tb_keypad_lock_menu.sv]
/*
 * Self-checking bench for the keypad security menu controller.
 * Assumes the operator model as APB master and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_keypad_lock_menu;
	logic                      pclk = 1'b0;
	logic                      presetn = 1'b0;
	logic                      run_switch = 1'b1;
	logic [11:0]               converter_code = 12'h001;
	wire logic                 psel, penable, pwrite, pready, pslverr;
	wire logic [11:0]          paddr;
	wire logic [31:0]          pwdata, prdata;
	wire logic                 program_led, setpoint_speed_led, err_led;
	keypad_lock_pkg::display_t display;
	keypad_lock_pkg::gates_t   gates;
	int                        miscompares = 0;
	int                        compares = 0;

	always #2.5 pclk = ~pclk;

	panel_operator i_op (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	keypad_lock_menu i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .run_switch(run_switch), .converter_code(converter_code),
		.program_led(program_led), .setpoint_speed_led(setpoint_speed_led),
		.err_led(err_led), .display(display), .gates(gates));

	// ==================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		i_op.xfer(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask
	task automatic press(input logic [3:0] k, input logic exp_err);
		logic [31:0] r;
		logic        e;
		while (err_led === 1'b1) @(posedge pclk);
		i_op.xfer(1'b1, keypad_lock_pkg::ADDR_KEY, {28'h0, k}, r, e);
		@(posedge pclk);
		#1;
		chk(32'(err_led), 32'(exp_err));
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ==================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		rd(keypad_lock_pkg::ADDR_PASS_ENTRY, 32'h000332);
		rd(keypad_lock_pkg::ADDR_PASS_DEF, 32'h000332);
		rd(keypad_lock_pkg::ADDR_MASK, 32'h0);
		rd(keypad_lock_pkg::ADDR_ERR_CYCLES, 32'(keypad_lock_pkg::ERR_CYCLES_RESET));
		i_op.xfer(1'b0, 12'h020, 32'h0, r, e);
		chk(32'(e), 32'h1);
		$display("test reset done");
	endtask
	task automatic t_level1();
		logic [3:0] bad[5] = '{4'h7, 4'h8, 4'h3, 4'h4, 4'h9};
		press(keypad_lock_pkg::KEY_SECURITY, 1'b0);
		chk(32'({program_led, setpoint_speed_led, display.all_flash}), 32'h7);
		chk(32'(display.digits), 32'h0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		chk(32'(display.digits), 32'h1);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		chk(32'(display.digits), 32'h0);
		press(keypad_lock_pkg::KEY_DOWN, 1'b0);
		chk(32'(display.digits), 32'h2);
		foreach (bad[i]) begin
			press(bad[i], 1'b1);
			chk(32'({display.all_flash, display.digits}), 32'h1000002);
		end
		press(keypad_lock_pkg::KEY_SECURITY, 1'b0);
		chk(32'(program_led), 32'h0);
		$display("test level one done");
	endtask
	task automatic t_lock();
		press(keypad_lock_pkg::KEY_SECURITY, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		chk(32'({display.flash_digit, display.digits}), 32'h01000332);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		chk(32'(display.digits), 32'h000333);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		chk(32'(display.all_flash), 32'h1);
		rd(keypad_lock_pkg::ADDR_PASS_ENTRY, 32'h000333);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		chk(32'(display.concealed_indicator), 32'h1);
		chk(32'(display.digits), 32'(keypad_lock_pkg::CONCEALED_CODE));
		press(keypad_lock_pkg::KEY_UP, 1'b1);
		press(keypad_lock_pkg::KEY_ENTER, 1'b1);
		press(keypad_lock_pkg::KEY_SECURITY, 1'b0);
		rd(keypad_lock_pkg::ADDR_PASS_DEF, 32'h0);
		press(keypad_lock_pkg::KEY_SECURITY, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b1);
		press(keypad_lock_pkg::KEY_SECURITY, 1'b0);
		rd(keypad_lock_pkg::ADDR_MASK, 32'h0);
		$display("test lock done");
	endtask
	task automatic t_unlock();
		press(keypad_lock_pkg::KEY_SECURITY, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		press(keypad_lock_pkg::KEY_DOWN, 1'b0);
		press(keypad_lock_pkg::KEY_LEFT, 1'b0);
		chk(32'(display.flash_digit), 32'h02);
		press(keypad_lock_pkg::KEY_RIGHT, 1'b0);
		chk(32'(display.flash_digit), 32'h01);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		press(keypad_lock_pkg::KEY_DOWN, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		chk(32'({display.concealed_indicator, display.digits}), 32'h000332);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		rd(keypad_lock_pkg::ADDR_PASS_DEF, 32'h0);
		chk(32'(gates), 32'h1D);
		press(keypad_lock_pkg::KEY_DOWN, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		press(keypad_lock_pkg::KEY_UP, 1'b0);
		press(keypad_lock_pkg::KEY_ENTER, 1'b0);
		rd(keypad_lock_pkg::ADDR_PASS_DEF, 32'h000333);
		chk(32'(gates), 32'h1F);
		press(keypad_lock_pkg::KEY_SECURITY, 1'b0);
		$display("test unlock done");
	endtask
	task automatic t_diagnostic_menu_key();
		logic [31:0] r;
		logic        e;
		chk(32'(gates.control_en), 32'h1);
		press(keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY, 1'b1);
		@(posedge pclk);
		run_switch <= 1'b0;
		press(keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY, 1'b1);
		@(posedge pclk);
		converter_code <= 12'h000;
		press(keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY, 1'b0);
		chk(32'(gates.control_en), 32'h0);
		press(keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY, 1'b0);
		chk(32'(gates.control_en), 32'h1);
		i_op.xfer(1'b1, keypad_lock_pkg::ADDR_ERR_CYCLES, 32'h3, r, e);
		run_switch <= 1'b1;
		press(keypad_lock_pkg::KEY_DIAGNOSTIC_MENU_KEY, 1'b1);
		r = 32'h2;
		repeat (8) begin
			@(posedge pclk);
			#1;
			if (err_led === 1'b1) r++;
		end
		chk(r, 32'h3);
		$display("test diagnostic and error lamp done");
	endtask

	// ==================================================
	// main sequence and watchdog
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_level1();
		t_lock();
		t_unlock();
		t_diagnostic_menu_key();
		results();
	end
	initial begin
		#200us;
		miscompares++;
		results();
	end
endmodule // tb_keypad_lock_menu

bind keypad_lock_menu keypad_lock_menu_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .run_switch(run_switch), .converter_code(converter_code),
	.program_led(program_led), .setpoint_speed_led(setpoint_speed_led),
	.err_led(err_led), .display(display), .gates(gates));

`default_nettype wire
